// ### hw/dpo_pkg.sv
// shared types and constants for the receive payload output port
// assumes one 40 mhz fabric clock; line pins are asynchronous to it
package dpo_pkg;

    // ==========================================================
    // frame geometry and nominal rates
    localparam int unsigned NIBBLES_PER_FRAME = 1176;   // payload nibbles per ds3 frame
    localparam int unsigned SERIAL_RATE_KHZ   = 44736;  // nominal serial payload clock
    localparam int unsigned SYNC_STAGES       = 2;

    // ==========================================================
    // payload clock shaping, in fabric clock cycles
    localparam logic [3:0] SER_HIGH_CYC = 4'h3;  // serial clock high time
    localparam logic [3:0] NIB_HIGH_CYC = 4'h4;  // nibble clock high time (short duty)
    localparam logic [3:0] MIN_LOW_CYC  = 4'h1;  // least low time between pulses

    // ==========================================================
    // reset values
    localparam logic [1:0] ASM_CNT_RST = 2'h0;
    localparam logic [3:0] TIMER_RST   = 4'h0;

    // one delivered unit: a bit (in data[0]) or a nibble
    typedef struct packed {
        logic [3:0] data;
        logic       oh;
        logic       sof;
    } dpo_word_t;

    localparam dpo_word_t WORD_RST = '{data: 4'h0, oh: 1'b0, sof: 1'b0};

    // payload clock phase
    typedef enum logic [1:0] {
        PC_LOW  = 2'b00,
        PC_HIGH = 2'b01
    } dpo_phase_t;

endpackage

// ### hw/dpo_payload_out.sv
// receive payload output port: serial or nibble delivery of inbound payload
// assumes an upstream framer presents one line bit per line clock, with an
// overhead flag and a start-of-frame flag, all changing with that clock

module dpo_payload_out
    import dpo_pkg::*;
#(
    parameter int unsigned BUF_DEPTH = 2
)
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // line side, asynchronous pins
    input  wire logic       rx_line_clock_in,
    input  wire logic       line_data_in,
    input  wire logic       line_overhead_in,
    input  wire logic       line_frame_start_in,
    input  wire logic       nibble_interface_select,
    // terminal equipment side
    output logic            rx_payload_clock,
    output logic            rx_serial_payload_out,
    output logic [3:0]      rx_nibble_payload_out,
    output logic            rx_overhead_indicator,
    output logic            rx_start_of_frame,
    // buffer has room for the next line word
    output logic            rx_buffer_ready
);

    // ==========================================================
    // elaboration checks
    if (BUF_DEPTH != 2)
        $error("dpo_payload_out: BUF_DEPTH must be 2");

    // ==========================================================
    // reset release and pin synchronisers
    logic [1:0] rst_sync_reg;
    logic       rst_n;
    logic [4:0] pin_s1_reg;
    logic [4:0] pin_s2_reg;
    logic       lclk_prev_reg;

    // reset asserts at once, releases after two edges
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    // first stage feeds only the second; line clock resets high so no false edge follows reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_reg    <= 5'h01;
            pin_s2_reg    <= 5'h01;
            lclk_prev_reg <= 1'b1;
        end
        else
        begin
            pin_s1_reg    <= {nibble_interface_select, line_frame_start_in,
                              line_overhead_in, line_data_in, rx_line_clock_in};
            pin_s2_reg    <= pin_s1_reg;
            lclk_prev_reg <= pin_s2_reg[0];
        end
    end

    logic mode_nib;
    logic line_bit_stb;
    logic mode_prev_reg;
    logic mode_chg;
    assign mode_nib     = pin_s2_reg[4];
    assign line_bit_stb = pin_s2_reg[0] & ~lclk_prev_reg;  // line clock rising edge
    assign mode_chg     = mode_nib ^ mode_prev_reg;

    // ==========================================================
    // nibble assembler (serial mode passes each bit straight on)
    logic [3:0] asm_sr_reg, asm_sr_next;
    logic [1:0] asm_cnt_reg, asm_cnt_next;
    logic       sof_pend_reg, sof_pend_next;
    logic       push;
    dpo_word_t  push_word;

    always_comb
    begin
        asm_sr_next   = asm_sr_reg;
        asm_cnt_next  = asm_cnt_reg;
        sof_pend_next = sof_pend_reg;
        push          = 1'b0;
        push_word     = WORD_RST;
        if (mode_chg)
        begin
            asm_cnt_next  = ASM_CNT_RST;
            sof_pend_next = 1'b0;
        end
        else if (line_bit_stb && !mode_nib)
        begin
            // overhead flag travels with its bit
            push           = 1'b1;
            push_word.data = {3'h0, pin_s2_reg[1]};
            push_word.oh   = pin_s2_reg[2];
            push_word.sof  = pin_s2_reg[3];
        end
        else if (line_bit_stb)
        begin
            // payload bits only, four per nibble
            if (pin_s2_reg[3])
            begin
                sof_pend_next = 1'b1;
                asm_cnt_next  = ASM_CNT_RST;  // realign on each frame
            end
            if (!pin_s2_reg[2])
            begin
                asm_sr_next  = {asm_sr_reg[2:0], pin_s2_reg[1]};
                asm_cnt_next = (pin_s2_reg[3] ? ASM_CNT_RST : asm_cnt_reg) + 2'h1;
                if (asm_cnt_next == ASM_CNT_RST)
                begin
                    // first nibble of the frame carries the flag
                    push           = 1'b1;
                    push_word.data = asm_sr_next;
                    push_word.sof  = sof_pend_next;
                    sof_pend_next  = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            asm_sr_reg    <= 4'h0;
            asm_cnt_reg   <= ASM_CNT_RST;
            sof_pend_reg  <= 1'b0;
            mode_prev_reg <= 1'b0;
        end
        else
        begin
            asm_sr_reg    <= asm_sr_next;
            asm_cnt_reg   <= asm_cnt_next;
            sof_pend_reg  <= sof_pend_next;
            mode_prev_reg <= mode_nib;
        end
    end

    // ==========================================================
    // two-entry buffer; the line cannot be stalled, so a full buffer
    // drops the word and shows it by rx_buffer_ready low
    dpo_word_t  buf_mem_reg [BUF_DEPTH];
    logic       wr_ptr_reg, rd_ptr_reg;
    logic [1:0] buf_cnt_reg, buf_cnt_next;
    logic       buf_valid;
    logic       pop;
    logic       do_push;

    assign buf_valid       = (buf_cnt_reg != 2'h0);
    assign rx_buffer_ready = (buf_cnt_reg != 2'h2);
    assign do_push         = push & rx_buffer_ready;

    always_comb
    begin
        buf_cnt_next = buf_cnt_reg;
        if (mode_chg)
            buf_cnt_next = 2'h0;
        else if (do_push && !pop)
            buf_cnt_next = buf_cnt_reg + 2'h1;
        else if (pop && !do_push)
            buf_cnt_next = buf_cnt_reg - 2'h1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            buf_mem_reg[0] <= WORD_RST;
            buf_mem_reg[1] <= WORD_RST;
            wr_ptr_reg     <= 1'b0;
            rd_ptr_reg     <= 1'b0;
            buf_cnt_reg    <= 2'h0;
        end
        else
        begin
            if (do_push)
                buf_mem_reg[wr_ptr_reg] <= push_word;
            wr_ptr_reg  <= mode_chg ? 1'b0 : (wr_ptr_reg ^ do_push);
            rd_ptr_reg  <= mode_chg ? 1'b0 : (rd_ptr_reg ^ pop);
            buf_cnt_reg <= buf_cnt_next;
        end
    end

    // ==========================================================
    // payload clock sequencer and output registers
    dpo_phase_t phase_reg, phase_next;
    logic [3:0] timer_reg, timer_next;
    logic       held_reg, held_next;   // nibble already shown, awaiting its pulse
    dpo_word_t  out_reg, out_next;
    dpo_word_t  head;

    assign head = buf_mem_reg[rd_ptr_reg];

    always_comb
    begin
        phase_next = phase_reg;
        timer_next = (timer_reg != TIMER_RST) ? timer_reg - 4'h1 : TIMER_RST;
        held_next  = held_reg;
        out_next   = out_reg;
        pop        = 1'b0;
        if (mode_chg)
        begin
            phase_next = PC_LOW;
            timer_next = TIMER_RST;
            held_next  = 1'b0;
            out_next   = WORD_RST;
        end
        else case (phase_reg)
            PC_LOW:
            begin
                if (timer_reg == TIMER_RST && buf_valid && !mode_nib)
                begin
                    // one clock per line bit, so it runs as the line runs
                    // bit, overhead and frame flag change at the rise
                    pop        = 1'b1;
                    out_next   = head;
                    phase_next = PC_HIGH;
                    timer_next = SER_HIGH_CYC - 4'h1;
                end
                else if (timer_reg == TIMER_RST && buf_valid && !held_reg)
                begin
                    // first nibble after start, no falling edge to wait for
                    pop       = 1'b1;
                    out_next  = head;
                    held_next = 1'b1;
                end
                else if (timer_reg == TIMER_RST && buf_valid)
                begin
                    // pulse only once the line has delivered the next nibble
                    phase_next = PC_HIGH;
                    timer_next = NIB_HIGH_CYC - 4'h1;
                end
            end
            PC_HIGH:
            begin
                if (timer_reg == TIMER_RST)
                begin
                    phase_next = PC_LOW;
                    timer_next = MIN_LOW_CYC - 4'h1;
                    if (mode_nib)
                    begin
                        // next nibble goes out at the fall
                        pop       = buf_valid;
                        out_next  = buf_valid ? head : WORD_RST;
                        held_next = buf_valid;
                    end
                end
            end
            default:
            begin
                phase_next = PC_LOW;
                timer_next = TIMER_RST;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_reg <= PC_LOW;
            timer_reg <= TIMER_RST;
            held_reg  <= 1'b0;
            out_reg   <= WORD_RST;
        end
        else
        begin
            phase_reg <= phase_next;
            timer_reg <= timer_next;
            held_reg  <= held_next;
            out_reg   <= out_next;
        end
    end

    // ==========================================================
    // pins; mode only selects which registered word fields appear
    // both forms fed from the same word
    assign rx_payload_clock      = (phase_reg == PC_HIGH);
    assign rx_serial_payload_out = out_reg.data[0] & ~mode_prev_reg;
    assign rx_nibble_payload_out = out_reg.data & {4{mode_prev_reg}};
    // nibble words never carry the overhead flag
    assign rx_overhead_indicator = out_reg.oh & ~mode_prev_reg;
    assign rx_start_of_frame     = out_reg.sof;

endmodule

// ### test/dpo_payload_out_assertions.sv
// port checker for the payload output port
// assumes select stays put; guards wait out its synchroniser
module dpo_payload_out_assertions
(
    // ports of the top module
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       rx_line_clock_in,
    input wire logic       line_data_in,
    input wire logic       line_overhead_in,
    input wire logic       line_frame_start_in,
    input wire logic       nibble_interface_select,
    input wire logic       rx_payload_clock,
    input wire logic       rx_serial_payload_out,
    input wire logic [3:0] rx_nibble_payload_out,
    input wire logic       rx_overhead_indicator,
    input wire logic       rx_start_of_frame,
    input wire logic       rx_buffer_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // mode guards: six cycles of steady select cover sync and flush
    logic [5:0] sel_hist_reg;
    logic       ser_ok;
    logic       nib_ok;
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            sel_hist_reg <= 6'h00;
        else
            sel_hist_reg <= {sel_hist_reg[4:0], nibble_interface_select};
    assign ser_ok = (sel_hist_reg == 6'h00) && !nibble_interface_select;
    assign nib_ok = (sel_hist_reg == 6'h3f) && nibble_interface_select;
    default clocking dck @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // port properties
    nib_idle_a: assert property (ser_ok |-> rx_nibble_payload_out == 4'h0)
        else $error("nibble bus active in serial mode");
    ser_idle_a: assert property (nib_ok |-> !rx_serial_payload_out)
        else $error("serial data active in nibble mode");
    oh_nib_low_a: assert property (nib_ok |-> !rx_overhead_indicator)
        else $error("overhead flag high in nibble mode");
    ser_at_rise_a: assert property (ser_ok && $changed(rx_serial_payload_out)
        |-> $rose(rx_payload_clock)) else $error("serial bit moved off clock rise");
    oh_at_rise_a: assert property (ser_ok && $changed(rx_overhead_indicator)
        |-> $rose(rx_payload_clock)) else $error("overhead flag moved off clock rise");
    sof_at_rise_a: assert property (ser_ok && $changed(rx_start_of_frame)
        |-> $rose(rx_payload_clock)) else $error("frame flag moved off clock rise");
    ser_pulse_a: assert property (ser_ok && $rose(rx_payload_clock)
        |-> rx_payload_clock[*3] ##1 !rx_payload_clock) else $error("serial clock shape");
    nib_pulse_a: assert property (nib_ok && $rose(rx_payload_clock)
        |-> rx_payload_clock[*4] ##1 !rx_payload_clock) else $error("nibble clock shape");
    nib_hold_a: assert property (nib_ok && $rose(rx_payload_clock)
        |=> $stable(rx_nibble_payload_out)[*3]) else $error("nibble moved while clock high");
endmodule

bind dpo_payload_out dpo_payload_out_assertions chk (
    .clk(clk), .rst_b(rst_b), .rx_line_clock_in(rx_line_clock_in),
    .line_data_in(line_data_in), .line_overhead_in(line_overhead_in),
    .line_frame_start_in(line_frame_start_in),
    .nibble_interface_select(nibble_interface_select), .rx_payload_clock(rx_payload_clock),
    .rx_serial_payload_out(rx_serial_payload_out), .rx_nibble_payload_out(rx_nibble_payload_out),
    .rx_overhead_indicator(rx_overhead_indicator), .rx_start_of_frame(rx_start_of_frame),
    .rx_buffer_ready(rx_buffer_ready));

// ### test/dpo_sink_model.sv
// terminal equipment model that consumes delivered payload
// assumes outputs settle within 1 ns of each payload clock rise
module dpo_sink_model
(
    // observed port outputs
    input wire logic       rx_payload_clock,
    input wire logic       rx_serial_payload_out,
    input wire logic [3:0] rx_nibble_payload_out,
    input wire logic       rx_overhead_indicator,
    input wire logic       rx_start_of_frame,
    input wire logic       nibble_mode,
    // capture results
    output logic [7:0]     cap_bits,
    output logic [7:0]     n_units,
    output logic [7:0]     n_sof
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        cap_bits = 8'h00;
        n_units = 8'h00;
        n_sof = 8'h00;
    end
    // capture on rise, overhead bits thrown away
    // outputs carry no delay here, so read them once the rising edge has settled
    always @(posedge rx_payload_clock)
    begin
        #1;
        if (rx_start_of_frame)
            n_sof <= n_sof + 8'h01;
        if (nibble_mode)
        begin
            cap_bits <= {cap_bits[3:0], rx_nibble_payload_out};
            n_units  <= n_units + 8'h01;
        end
        else if (!rx_overhead_indicator)
        begin
            cap_bits <= {cap_bits[6:0], rx_serial_payload_out};
            n_units  <= n_units + 8'h01;
        end
    end
endmodule

// ### test/test_dpo_payload_out.sv
// self-checking bench: a serial frame, then a nibble frame
// the bench plays the framer, the sink model the terminal equipment
module test_dpo_payload_out;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rst_b, lclk, ldat, loh, lsof, nsel;
    logic       pclk, sdat, oh, sof, rdy;
    logic [3:0] nib;
    logic [7:0] cap, nu, ns;
    int         n_mismatch = 0;
    int         total_checks = 0;

    dpo_payload_out uut (.clk(clk), .rst_b(rst_b), .rx_line_clock_in(lclk),
        .line_data_in(ldat), .line_overhead_in(loh), .line_frame_start_in(lsof),
        .nibble_interface_select(nsel), .rx_payload_clock(pclk),
        .rx_serial_payload_out(sdat), .rx_nibble_payload_out(nib),
        .rx_overhead_indicator(oh), .rx_start_of_frame(sof), .rx_buffer_ready(rdy));
    dpo_sink_model sink (.rx_payload_clock(pclk), .rx_serial_payload_out(sdat),
        .rx_nibble_payload_out(nib), .rx_overhead_indicator(oh), .rx_start_of_frame(sof),
        .nibble_mode(nsel), .cap_bits(cap), .n_units(nu), .n_sof(ns));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one line bit per 200 ns; the line clock rests high between frames
    task automatic send_bit(input logic d, input logic o, input logic f);
        @(posedge clk);
        ldat <= d;
        loh <= o;
        lsof <= f;
        lclk <= 1'b0;
        repeat (4) @(posedge clk);
        lclk <= 1'b1;
        repeat (3) @(posedge clk);
        ldat <= ~d; // held time over: show a wrong level
    endtask
    task automatic send_seq(input logic [15:0] b, input logic [15:0] o, input int n);
        for (int i = n - 1; i >= 0; i--)
            send_bit(b[i], o[i], i == n - 1);
    endtask
    // bounded wait for the sink to reach a unit count
    task automatic wait_units(input logic [7:0] exp);
        int k;
        k = 0;
        while (nu !== exp && k < 80)
        begin
            @(posedge clk);
            k++;
        end
        if (nu !== exp)
        begin
            n_mismatch++;
            tally_and_finish();
        end
        else
            check(nu, exp);
    endtask
    // overhead start bit, then eight payload bits
    task automatic serial_frame();
        send_seq(16'h01b2, 16'h0100, 9);
        wait_units(8'h08);
        check(cap, 8'hb2);
        check(ns, 8'h01);
        check({4'h0, nib}, 8'h00);
        check({7'h00, rdy}, 8'h01);
    endtask
    // three nibbles with an overhead bit inside; one nibble stays pending
    task automatic nibble_frame();
        nsel <= 1'b1;
        repeat (10) @(posedge clk);
        send_seq(16'h19a7, 16'h0100, 13);
        wait_units(8'h0a);
        check(cap, 8'hca);
        check(ns, 8'h02);
        check({6'h00, oh, sdat}, 8'h00);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        rst_b = 1'b0;
        lclk = 1'b1;
        ldat = 1'b0;
        loh = 1'b0;
        lsof = 1'b0;
        nsel = 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
        serial_frame();
        nibble_frame();
        tally_and_finish();
    end
endmodule
